// >>> epm_pkg.sv
/*
  Shared constants and types of the management/event slice of the
  ethernet_controller: register offsets, field positions, reset values and
  frame layout.
  Assumes a 32-bit APB register bus with byte addresses.
*/
`default_nettype none
package epm_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;              // 1-Kbyte space
  localparam logic [9:0] EVT_OFF    = 10'h004;      // event_flag_reg
  localparam logic [9:0] MASK_OFF   = 10'h008;      // event_mask_reg
  localparam logic [9:0] ENA_OFF    = 10'h024;      // controller_enable_reg
  localparam logic [9:0] FRAME_OFF  = 10'h040;      // mgmt_frame_reg
  localparam logic [9:0] SPEED_OFF  = 10'h044;      // mgmt_speed_reg
  localparam int unsigned STATS_BIT = 9;            // upper half select

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] EVT_RST   = 32'h0000_0000;
  localparam logic [31:0] MASK_RST  = 32'h0000_0000;
  localparam logic [5:0]  SPD_RST   = 6'h00;
  localparam int unsigned MGMT_DONE_BIT = 0;        // done flag position
  localparam int unsigned ENA_RESET_BIT = 0;        // self-clearing reset
  localparam int unsigned ENA_EN_BIT    = 1;        // controller enable
  localparam int unsigned SPD_LSB       = 1;        // divisor field lsb
  localparam int unsigned SPD_W         = 6;        // divisor width
  localparam int unsigned SPD_NOPRE_BIT = 7;        // omit preamble

  // ----------------------------------------------------------------
  // Frame layout and bit positions in the 64-bit serial sequence
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [5:0] PRE_BITS   = 6'h20;        // 32 ones
  localparam logic [5:0] TA_START   = 6'h2E;        // first turnaround bit
  localparam logic [5:0] DATA_START = 6'h30;        // first data bit
  localparam logic [5:0] LAST_BIT   = 6'h3F;

  typedef struct packed {
    logic [1:0]  st;     // start pattern
    logic [1:0]  op;     // opcode
    logic [4:0]  pa;     // PHY address
    logic [4:0]  ra;     // register address
    logic [1:0]  ta;     // turnaround
    logic [15:0] data;   // data
  } epm_frame_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_SHIFT = 2'h1,
    ST_DONE  = 2'h3
  } epm_state_t;
endpackage
`default_nettype wire

// >>> epm_flag_bit.sv
/*
  One sticky event flag: set by hardware, cleared by writing one.
  Assumes set and clear are single-cycle strobes on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module epm_flag_bit (
  input  wire logic sys_clk,  // system clock
  input  wire logic rst,      // async reset, high
  input  wire logic ce,       // clock enable
  input  wire logic set,      // hardware event
  input  wire logic clr,      // software write-one
  output logic      q         // flag value
);
  // Set wins so an event in the clearing cycle is kept
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= 1'b0;
    end else if (ce) begin
      if (set) begin
        q <= 1'b1;
      end else if (clr) begin
        q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> epm_mdc_gen.sv
/*
  Management clock generator: divides sys_clk by twice the divisor.
  Assumes the divisor input is a register; a new value is taken at an
  edge of the generated clock, or in every cycle while it is stopped.
*/
`timescale 1ns/1ps
`default_nettype none
module epm_mdc_gen #(
  parameter int unsigned DIV_W = 6  // divisor width
) (
  input  wire logic             sys_clk,  // system clock
  input  wire logic             rst,      // async reset, high
  input  wire logic             ce,       // clock enable
  input  wire logic [DIV_W-1:0] div_in,   // requested divisor
  output logic                  mdc,      // management clock
  output logic                  rise,     // pulse with rising edge
  output logic                  fall      // pulse with falling edge
);
  logic [DIV_W-1:0] active_reg;
  logic [DIV_W-1:0] cnt_reg;

  // Divisor sampled at an edge, or each cycle while stopped, keeps each half period whole
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      active_reg <= '0;
      cnt_reg    <= '0;
      mdc        <= 1'b0;
      rise       <= 1'b0;
      fall       <= 1'b0;
    end else if (ce) begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (active_reg == '0) begin
        mdc        <= 1'b0;
        cnt_reg    <= '0;
        active_reg <= div_in;
      end else if (cnt_reg == active_reg - 1'b1) begin
        cnt_reg    <= '0;
        mdc        <= ~mdc;
        rise       <= ~mdc;
        fall       <= mdc;
        active_reg <= div_in;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_mdc_stopped: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && active_reg == '0) |=> !mdc)
    else $error("management clock runs with zero divisor");
  a_half_period: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && active_reg != '0 && cnt_reg == active_reg - 1'b1)
      |=> $changed(mdc))
    else $error("management clock missed its toggle");
  a_hold_between: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && active_reg != '0 && cnt_reg != active_reg - 1'b1)
      |=> $stable(mdc))
    else $error("management clock toggled early");
endmodule
`default_nettype wire

// >>> epm_ctrl.sv
/*
  Control/status slice of the ethernet_controller: event flags, mask,
  interrupt line, enable register and the serial management master.
  Assumes an APB master on sys_clk and an external pull-up on the
  management data wire; the testbench resolves the wire from the enable.
*/
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module epm_ctrl #(
  parameter int unsigned EVT_W = 32  // event input count
) (
  input  wire logic                         sys_clk,      // system clock
  input  wire logic                         rst,          // async reset
  input  wire logic                         ce,           // clock enable
  input  wire logic                         psel,         // APB select
  input  wire logic                         penable,      // APB enable
  input  wire logic                         pwrite,       // APB write
  input  wire logic [epm_pkg::ADDR_W-1:0]   paddr,        // APB address
  input  wire logic [31:0]                  pwdata,       // APB wdata
  output logic [31:0]                       prdata,       // APB rdata
  output logic                              pready,       // APB ready
  output logic                              pslverr,      // APB error
  input  wire logic [EVT_W-1:0]             evt_set,      // event pulses
  input  wire logic                         hw_disable,   // disable req
  output logic                              irq,          // interrupt
  output logic                              ctrl_enable,  // enable field
  output logic                              ctrl_reset,   // reset pulse
  output logic                              mgmt_clock_pin, // mgmt clock
  output logic                              mgmt_data_o,  // pin out value
  output logic                              mgmt_data_oe, // pin drive
  input  wire logic                         mgmt_data_i   // pin in value
);
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        setup;
  logic        wr_en;
  logic        wr_evt, wr_mask, wr_ena, wr_frame, wr_speed;
  logic [31:0] flags_q;
  logic [31:0] mask_reg;
  logic        ena_en_reg, ena_rst_reg;
  epm_pkg::epm_frame_t frame_reg;
  logic [epm_pkg::SPD_W-1:0] spd_reg;
  logic        nopre_reg;
  logic [31:0] rd_next;
  logic        err_next;
  logic        err_reg;

  assign setup    = psel && !penable;
  assign wr_en    = psel && penable && pwrite && ce;
  assign wr_evt   = wr_en && paddr == epm_pkg::EVT_OFF;
  assign wr_mask  = wr_en && paddr == epm_pkg::MASK_OFF;
  assign wr_ena   = wr_en && paddr == epm_pkg::ENA_OFF;
  assign wr_frame = wr_en && paddr == epm_pkg::FRAME_OFF;
  assign wr_speed = wr_en && paddr == epm_pkg::SPEED_OFF;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && err_reg;

  // Read mux; stats half reads zero since its counters live elsewhere
  always_comb begin
    rd_next  = 32'h0000_0000;
    err_next = 1'b0;
    if (paddr[epm_pkg::STATS_BIT]) begin
      rd_next = 32'h0000_0000;
    end else begin
      case (paddr)
        epm_pkg::EVT_OFF:   rd_next = flags_q;
        epm_pkg::MASK_OFF:  rd_next = mask_reg;
        epm_pkg::ENA_OFF: begin
          rd_next[epm_pkg::ENA_EN_BIT]    = ena_en_reg;
          rd_next[epm_pkg::ENA_RESET_BIT] = ena_rst_reg;
        end
        epm_pkg::FRAME_OFF: rd_next = frame_reg;
        epm_pkg::SPEED_OFF: begin
          rd_next[epm_pkg::SPD_LSB +: epm_pkg::SPD_W] = spd_reg;
          rd_next[epm_pkg::SPD_NOPRE_BIT]             = nopre_reg;
        end
        default:            err_next = 1'b1;
      endcase
    end
  end

  // Read data captured in setup so the access phase needs no wait
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (ce && setup) begin
      prdata  <= rd_next;
      err_reg <= err_next;
    end
  end

  // ----------------------------------------------------------------
  // Event flags, mask and interrupt
  // ----------------------------------------------------------------
  logic        done_pulse;
  logic [31:0] set_vec;

  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[EVT_W-1:0] = evt_set;
    set_vec[epm_pkg::MGMT_DONE_BIT] = evt_set[epm_pkg::MGMT_DONE_BIT]
                                      | done_pulse;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_flag
      epm_flag_bit u_flag (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .set     (set_vec[gi]),
        .clr     (wr_evt && pwdata[gi]),
        .q       (flags_q[gi])
      );
    end
  endgenerate

  // Mask register, cleared by hardware reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_reg <= epm_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask_reg <= pwdata;
    end
  end

  // Level interrupt: drops only via flag clear or mask clear
  assign irq = |(flags_q & mask_reg);

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  // Reset field self-clears and also drops enable, as does hw_disable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ena_en_reg  <= 1'b0;
      ena_rst_reg <= 1'b0;
    end else if (ce) begin
      if (ena_rst_reg || hw_disable) begin
        ena_en_reg  <= 1'b0;
        ena_rst_reg <= 1'b0;
      end else if (wr_ena) begin
        ena_en_reg  <= pwdata[epm_pkg::ENA_EN_BIT];
        ena_rst_reg <= pwdata[epm_pkg::ENA_RESET_BIT];
      end
    end
  end
  assign ctrl_enable = ena_en_reg;
  assign ctrl_reset  = ena_rst_reg;

  // ----------------------------------------------------------------
  // Speed register and clock divider
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      spd_reg   <= epm_pkg::SPD_RST;
      nopre_reg <= 1'b0;
    end else if (wr_speed) begin
      spd_reg   <= pwdata[epm_pkg::SPD_LSB +: epm_pkg::SPD_W];
      nopre_reg <= pwdata[epm_pkg::SPD_NOPRE_BIT];
    end
  end

  logic mdc_rise, mdc_fall;
  epm_mdc_gen #(
    .DIV_W (epm_pkg::SPD_W)
  ) u_mdc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .div_in  (spd_reg),
    .mdc     (mgmt_clock_pin),
    .rise    (mdc_rise),
    .fall    (mdc_fall)
  );

  // ----------------------------------------------------------------
  // Management frame engine
  // ----------------------------------------------------------------
  epm_pkg::epm_state_t state_reg;
  logic        pend_reg;
  logic [31:0] tx_reg;
  logic [15:0] rx_reg;
  logic [5:0]  idx_reg;
  logic        shown_reg;
  logic        is_rd;
  logic        start;
  logic        last_rise;

  assign is_rd     = tx_reg[29:28] == epm_pkg::OP_READ;  // Read opcode
  assign start     = state_reg == epm_pkg::ST_IDLE && pend_reg
                     && spd_reg != '0;
  assign last_rise = state_reg == epm_pkg::ST_SHIFT && mdc_rise
                     && shown_reg && idx_reg == epm_pkg::LAST_BIT;
  assign done_pulse = ce && state_reg == epm_pkg::ST_DONE;

  // Any frame write arms a request; it waits while the divisor is zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else if (ce) begin
      if (wr_frame) begin
        pend_reg <= 1'b1;
      end else if (start) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // Frame register has no reset; read data replaces only the data field
  always_ff @(posedge sys_clk) begin
    if (wr_frame) begin
      frame_reg <= pwdata;
    end else if (ce && last_rise && is_rd) begin
      frame_reg.data <= {rx_reg[14:0], mgmt_data_i};
    end
  end

  // Sequencer: bits launched on falling edges, sampled on rising edges
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg    <= epm_pkg::ST_IDLE;
      tx_reg       <= 32'h0000_0000;
      rx_reg       <= 16'h0000;
      idx_reg      <= 6'h00;
      shown_reg    <= 1'b0;
      mgmt_data_o  <= 1'b1;
      mgmt_data_oe <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        epm_pkg::ST_IDLE: begin
          if (start) begin
            tx_reg    <= frame_reg;
            idx_reg   <= nopre_reg ? epm_pkg::PRE_BITS : 6'h00;
            shown_reg <= 1'b0;
            state_reg <= epm_pkg::ST_SHIFT;
          end
        end
        epm_pkg::ST_SHIFT: begin
          if (mdc_fall) begin
            // Preamble ones, then frame bits MSB first
            mgmt_data_o  <= idx_reg < epm_pkg::PRE_BITS ? 1'b1
                            : tx_reg[~idx_reg[4:0]];
            mgmt_data_oe <= !(tx_reg[29:28] == epm_pkg::OP_READ
                              && idx_reg >= epm_pkg::TA_START);
            shown_reg    <= 1'b1;
          end else if (mdc_rise && shown_reg) begin
            if (tx_reg[29:28] == epm_pkg::OP_READ
                && idx_reg >= epm_pkg::DATA_START) begin
              rx_reg <= {rx_reg[14:0], mgmt_data_i};
            end
            if (idx_reg == epm_pkg::LAST_BIT) begin
              state_reg <= epm_pkg::ST_DONE;
            end else begin
              idx_reg <= idx_reg + 6'h01;
            end
          end
        end
        epm_pkg::ST_DONE: begin
          mgmt_data_oe <= 1'b0;
          state_reg    <= epm_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= epm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_evt_w1c: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_evt && set_vec == 32'h0000_0000)
      |=> flags_q == ($past(flags_q) & ~$past(pwdata)))
    else $error("event flags not cleared by write one");
  a_irq_raise: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && done_pulse && mask_reg[epm_pkg::MGMT_DONE_BIT] && !wr_mask)
      |=> irq)
    else $error("masked-in done event raised no interrupt");
  a_irq_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (irq && !wr_evt && !wr_mask) |=> irq)
    else $error("interrupt dropped without a clear");
  a_reset_zero: assert property (@(posedge sys_clk)
    rst |-> (flags_q == epm_pkg::EVT_RST && mask_reg == epm_pkg::MASK_RST))
    else $error("flags or mask not zero in reset");
  a_no_start_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == epm_pkg::ST_IDLE && spd_reg == '0) |=>
      state_reg == epm_pkg::ST_IDLE)
    else $error("frame started with zero divisor");
  a_pend_launch: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && start) |=> state_reg == epm_pkg::ST_SHIFT)
    else $error("pending frame not launched");
  a_pre_ones: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == epm_pkg::ST_SHIFT && shown_reg
     && idx_reg < epm_pkg::PRE_BITS) |-> (mgmt_data_o && mgmt_data_oe))
    else $error("preamble bit not a driven one");
  a_read_release: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == epm_pkg::ST_SHIFT && shown_reg
     && tx_reg[29:28] == epm_pkg::OP_READ
     && idx_reg >= epm_pkg::DATA_START) |-> !mgmt_data_oe)
    else $error("pin driven during read data");
  a_done_once: assert property (@(posedge sys_clk) disable iff (rst)
    done_pulse |-> ($past(state_reg) == epm_pkg::ST_SHIFT
                    ##1 !done_pulse))
    else $error("done event not single per frame");
  a_write_keep: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && last_rise && tx_reg[29:28] != epm_pkg::OP_READ && !wr_frame)
      |=> $stable(frame_reg))
    else $error("write frame altered the frame register");

  c_read_done: cover property (@(posedge sys_clk) disable iff (rst)
    done_pulse && tx_reg[29:28] == epm_pkg::OP_READ);
  c_write_done: cover property (@(posedge sys_clk) disable iff (rst)
    done_pulse && tx_reg[29:28] != epm_pkg::OP_READ);
  c_irq_rise: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(irq));
  c_nopre_start: cover property (@(posedge sys_clk) disable iff (rst)
    start && nopre_reg);
endmodule
`default_nettype wire

// >>> epm_phy_model.sv
/* PHY management port model: answers read frames on the data wire.
   Assumes the bench resolves the wire with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module epm_phy_model (
  input  wire logic        mdc,     // management clock
  input  wire logic        mdio,    // resolved wire level
  input  wire logic [15:0] rd_data, // value to return
  output logic             drv_oe,  // model drives wire
  output logic             drv_o    // model drive value
);
  // ---------------------------------------------------------------
  // Frame tracking
  // ---------------------------------------------------------------
  logic [5:0] sh;
  int         n;
  initial begin
    sh = 6'h3F;
    n = 0;
    drv_oe = 1'b0;
    drv_o = 1'b0;
  end
  // Sample on rise, launch on fall; a read start follows preamble ones
  always @(mdc) begin
    if (mdc) begin
      sh = {sh[4:0], mdio};
      if (n == 0 && sh == 6'h36) n = 1;
      else if (n > 0 && n < 11) n++;
    end else if (n >= 11) begin
      drv_oe = (n >= 12 && n <= 28);
      drv_o = (n > 12 && n < 29) ? rd_data[28 - n] : 1'b0;
      n = (n == 29) ? 0 : n + 1;
    end
  end
endmodule
`default_nettype wire

// >>> tb_phy_mgmt_master_with_event_flags.sv
/* Self-checking bench of epm_ctrl: APB tasks, scenarios, verdict.
   Assumes the PHY model and a pull-up on the data wire. */
`timescale 1ns/1ps
`default_nettype none
module tb_phy_mgmt_master_with_event_flags;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, evt_set, rd_v;
  logic        irq, c_en, c_rst, mdc, d_o, d_oe, p_oe, p_o, hw_dis;
  logic [63:0] cap;
  wire         mdio = d_oe ? d_o : (p_oe ? p_o : 1'b1); // Pull-up
  int          err_total, tests_run, rises, all_r, n_crst;
  realtime     t_prev, t_per;
  localparam logic [31:0] WRF = 32'h5192_1234;
  localparam logic [31:0] RDF = 32'h608A_0000;
  // Divisor 20: 2.5 MHz management clock from 100 MHz
  localparam logic [31:0] SPD = 32'h0000_0028;
  epm_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt_set(evt_set), .hw_disable(hw_dis), .irq(irq),
    .ctrl_enable(c_en), .ctrl_reset(c_rst), .mgmt_clock_pin(mdc),
    .mgmt_data_o(d_o), .mgmt_data_oe(d_oe), .mgmt_data_i(mdio));
  epm_phy_model u_phy (.mdc(mdc), .mdio(mdio), .rd_data(16'hA5C3),
    .drv_oe(p_oe), .drv_o(p_o));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Wire capture; only device-driven bits count toward frame length
  always @(posedge mdc) begin
    all_r++;
    if (d_oe) begin
      rises++;
      cap = {cap[62:0], mdio};
    end
    t_per = $realtime - t_prev;
    t_prev = $realtime;
  end
  // Cycles with the controller reset pulse high
  always @(posedge sys_clk) begin
    if (c_rst === 1'b1) n_crst++;
  end
  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Idle edge after each transfer keeps drives one per time step
  task automatic apb(input logic w, input logic [9:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) err_total++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [9:0] a);
    logic e;
    apb(1'b0, a, 32'h0, rd_v, e);
  endtask
  // Run one frame and wait for the done interrupt (mask bit 0 set)
  task automatic frame(input logic [31:0] spd, fr, input int n);
    int k;
    k = 0;
    wr(epm_pkg::SPEED_OFF, spd);
    rises = 0;
    wr(epm_pkg::FRAME_OFF, fr);
    while (irq !== 1'b1 && k < 4000) begin
      @(posedge sys_clk);
      k++;
    end
    check("done", {31'h0, irq}, 32'h1);
    check("bits", rises, n);
    check("period", int'(t_per), 400);
    wr(epm_pkg::EVT_OFF, 32'h1);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic e;
    rd(epm_pkg::EVT_OFF);
    check("evt_rst", rd_v, 32'h0);
    rd(epm_pkg::MASK_OFF);
    check("mask_rst", rd_v, 32'h0);
    apb(1'b0, 10'h00C, 32'h0, rd_v, e);
    check("unmapped", {31'h0, e}, 32'h1);
    apb(1'b1, 10'h200, 32'hFFFF_FFFF, rd_v, e);
    rd(10'h200);
    check("stats", {e, rd_v[30:0]}, 32'h0);
    evt_set <= 32'h20;
    @(posedge sys_clk);
    evt_set <= 32'h0;
    wr(epm_pkg::MASK_OFF, 32'h20);
    check("irq_on", {31'h0, irq}, 32'h1);
    wr(epm_pkg::EVT_OFF, 32'hFFFF_FFDF);
    rd(epm_pkg::EVT_OFF);
    check("w0_keep", rd_v, 32'h20);
    wr(epm_pkg::MASK_OFF, 32'h0);
    check("irq_mask", {31'h0, irq}, 32'h0);
    wr(epm_pkg::MASK_OFF, 32'h21);
    wr(epm_pkg::EVT_OFF, 32'h20);
    rd(epm_pkg::EVT_OFF);
    check("w1_clr", {irq, rd_v[30:0]}, 32'h0);
    wr(epm_pkg::ENA_OFF, 32'h2);
    check("ena_sw", {31'h0, c_en}, 32'h1);
    hw_dis <= 1'b1;
    @(posedge sys_clk);
    hw_dis <= 1'b0;
    rd(epm_pkg::ENA_OFF);
    check("ena_hw", rd_v, 32'h0);
    wr(epm_pkg::ENA_OFF, 32'h3);
    rd(epm_pkg::ENA_OFF);
    check("ena_rst", rd_v, 32'h0);
    check("rst_pulse", n_crst, 1);
  endtask
  task automatic t_mgmt();
    frame(SPD, WRF, 64);
    check("wire", cap[31:0], WRF);
    check("pre", cap[63:32], 32'hFFFF_FFFF);
    rd(epm_pkg::FRAME_OFF);
    check("wr_back", rd_v, WRF);
    frame(SPD, RDF, 46);
    rd(epm_pkg::FRAME_OFF);
    check("rd_back", rd_v, {RDF[31:16], 16'hA5C3});
    frame(SPD | 32'h80, WRF, 32);
    check("wire_np", cap[31:0], WRF);
    wr(epm_pkg::SPEED_OFF, 32'h0);
    repeat (20) @(posedge sys_clk);
    all_r = 0;
    rises = 0;
    wr(epm_pkg::FRAME_OFF, WRF);
    repeat (200) @(posedge sys_clk);
    check("no_clk", all_r, 0);
    wr(epm_pkg::SPEED_OFF, SPD);
    repeat (2800) @(posedge sys_clk);
    check("late", {rises[30:0], irq}, 32'h81);
  endtask
  task automatic give_verdict();
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {rst, psel, penable, pwrite, hw_dis} = 5'h10;
    {paddr, pwdata, evt_set, cap} = '0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_mgmt();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
